// ---- pkg/wdg_pkg.sv ----
// shared constants and state layout of the reload-guarded watchdog
package wdg_pkg;
    // special function register addresses
    localparam logic [7:0] WDG_ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] WDG_ADDR_COUNT = 8'hff;
    // power control field positions
    localparam int WDG_IDLE_BIT = 0;
    localparam int WDG_PD_BIT = 1;
    localparam int WDG_RLE_BIT = 4;
    // reset values and counter maximum
    localparam logic [7:0] WDG_POWER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WDG_COUNT_RESET = 8'h00;
    localparam logic [7:0] WDG_COUNT_MAX = 8'hff;
    // timing: oscillator periods per machine cycle, prescaler width
    localparam int WDG_MC_DIV = 12;
    localparam int WDG_PRESC_WIDTH = 11;
    // outgoing reset pulse length in machine cycles and in clocks
    localparam int WDG_RST_MC = 3;
    localparam int WDG_RST_PULSE_CLKS = WDG_RST_MC * WDG_MC_DIV;
    localparam int WDG_RST_CNT_W = 6;
    localparam logic [WDG_RST_CNT_W-1:0] WDG_RST_LOAD =
        WDG_RST_CNT_W'(WDG_RST_PULSE_CLKS);
    // whole register state of the watchdog top
    typedef struct packed {
        logic [7:0] power_control; // power control bits
        logic [7:0] count;                 // watchdog counter
        logic [WDG_RST_CNT_W-1:0] rst_cnt; // reset pulse clocks left
        logic [7:0] rdata;                 // registered read data
        logic en_meta; // enable pin, first stage
        logic en_sync; // enable pin, synchronised
    } wdg_state_s;
endpackage : wdg_pkg

// ---- pkg/wdg_tick_if.sv ----
// carrier between the watchdog control and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface wdg_tick_if;
    logic clear; // hold prescaler at zero
    logic tick;  // one-cycle terminal pulse of the prescaler
    modport ctrl (output clear, input tick);
    modport presc (input clear, output tick);
endinterface : wdg_tick_if
`default_nettype wire

// ---- src/wdg_prescaler.sv ----
// machine-cycle divider plus prescaler that paces the watchdog counter
`timescale 1ns/1ps
`default_nettype none
module wdg_prescaler
    import wdg_pkg::*;
#(
    parameter int PRESC_WIDTH = WDG_PRESC_WIDTH
) (
    input wire logic clk_in,
    input wire logic srst_in,
    wdg_tick_if.presc tick_if
);
    // divider and prescaler state
    typedef struct packed {
        logic [3:0] mc;                // oscillator periods in machine cycle
        logic [PRESC_WIDTH-1:0] pre;   // prescaler count
    } wdg_presc_s;

    localparam logic [3:0] MC_LAST = 4'(WDG_MC_DIV - 1);

    wdg_presc_s st;
    wdg_presc_s next_st;
    logic mc_end;

    // machine cycle ends every twelfth clock
    assign mc_end = (st.mc == MC_LAST);
    // terminal output: last clock of the last prescaler state
    assign tick_if.tick = mc_end && (&st.pre) && !tick_if.clear;

    // next state: divide by twelve, then by the prescaler
    always_comb begin
        next_st = st;
        if (tick_if.clear) begin
            next_st = '0;
        end else if (mc_end) begin
            next_st.mc = 4'h0;
            next_st.pre = st.pre + PRESC_WIDTH'(1);
        end else begin
            next_st.mc = st.mc + 4'h1;
        end
    end

    // single state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // helper: clocks since the last tick or clear
    int gap;
    always_ff @(posedge clk_in) begin
        if (srst_in || tick_if.clear || tick_if.tick) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end

    localparam int PERIOD = WDG_MC_DIV * (2 ** PRESC_WIDTH);

    property p_tick_period;
        @(posedge clk_in) disable iff (srst_in)
        tick_if.tick && !$past(tick_if.clear) |-> gap == PERIOD - 1;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("prescaler tick spacing wrong");
endmodule : wdg_prescaler
`default_nettype wire

// ---- src/wdg_top.sv ----
// watchdog timer with two-stage reload and power-down lockout
//
// Functional notes
// - eight-bit counter advanced by eleven-bit prescaler
// - prescaler fed at oscillator divided by twelve
// - counter overflow fires internal chip reset
// - overflow drives reset pin three machine cycles
// - low enable pin: watchdog runs, unstoppable
// - high enable pin: no watchdog reset
// - accepted counter write clears reload enable
// - counter write ignored while reload enable clear
// - up-counter: zero longest, all-ones shortest
// - keeps counting during idle mode
// - power-down bit held zero while enabled
`timescale 1ns/1ps
`default_nettype none
module wdg_top
    import wdg_pkg::*;
#(
    parameter int PRESC_WIDTH = WDG_PRESC_WIDTH // shorten in simulation
) (
    input wire logic clk_in,                    // oscillator clock
    input wire logic srst_in,                   // chip reset, sync high
    input wire logic watchdog_enable_n_pin_in,  // enable pin, active low
    input wire logic [7:0] sfr_addr_in,         // sfr address
    input wire logic sfr_wr_in,                 // sfr write strobe
    input wire logic [7:0] sfr_wdata_in,        // sfr write data
    input wire logic sfr_rd_in,                 // sfr read strobe
    output logic [7:0] sfr_rdata_out,           // read data, next cycle
    output logic idle_out,                      // idle mode request
    output logic power_down_out,                // power-down request
    output logic internal_reset_out,            // chip reset request
    output logic rst_pin_out,                   // reset pin drive value
    output logic rst_pin_oe_out                 // reset pin drive enable
);
    wdg_state_s st;
    wdg_state_s next_st;
    wdg_tick_if tick_if ();

    logic enabled;     // watchdog active
    logic pulse_on;    // reset pulse in progress
    logic wr_pwr;      // power control write
    logic wr_count;    // counter write attempt
    logic wr_accept;   // counter write allowed
    logic overflow;    // counter wraps on this tick

    // read multiplexer; unmapped addresses read zero
    function automatic logic [7:0] sfr_read(input logic [7:0] addr,
                                            input logic [7:0] pwr,
                                            input logic [7:0] count);
        logic [7:0] r;
        r = 8'h00;
        if (addr == WDG_ADDR_POWER_CONTROL) begin
            r = pwr;
        end else if (addr == WDG_ADDR_COUNT) begin
            r = count;
        end
        return r;
    endfunction : sfr_read

    // only the synchronised level of the pin is looked at
    assign enabled = !st.en_sync;
    assign pulse_on = (st.rst_cnt != '0);
    assign wr_pwr = sfr_wr_in && (sfr_addr_in == WDG_ADDR_POWER_CONTROL);
    assign wr_count = sfr_wr_in && (sfr_addr_in == WDG_ADDR_COUNT);
    // two-stage reload guards against runaway code
    assign wr_accept = wr_count && st.power_control[WDG_RLE_BIT];
    // a reload in the same cycle as the last tick rescues the chip
    assign overflow = enabled && tick_if.tick && !wr_accept &&
                      (st.count == WDG_COUNT_MAX) && !pulse_on;

    // prescaler is held cleared when off and while the chip resets
    assign tick_if.clear = !enabled || pulse_on;

    wdg_prescaler #(
        .PRESC_WIDTH(PRESC_WIDTH)
    ) u_presc (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tick_if(tick_if)
    );

    // next state of all registers
    always_comb begin
        next_st = st;
        // two-flop synchroniser on the enable pin
        next_st.en_meta = watchdog_enable_n_pin_in;
        next_st.en_sync = st.en_meta;
        // read data is registered; zero when not read
        next_st.rdata = sfr_rd_in ?
            sfr_read(sfr_addr_in, st.power_control, st.count) : 8'h00;
        if (pulse_on) begin
            // watchdog reset acts like a chip reset on this block
            next_st.rst_cnt = st.rst_cnt - WDG_RST_CNT_W'(1);
            next_st.power_control = WDG_POWER_CONTROL_RESET;
            next_st.count = WDG_COUNT_RESET;
        end else if (overflow) begin
            next_st.rst_cnt = WDG_RST_LOAD;
        end else begin
            // power control write; power-down locked out when enabled
            if (wr_pwr) begin
                next_st.power_control = sfr_wdata_in;
                if (enabled) begin
                    next_st.power_control[WDG_PD_BIT] = 1'b0;
                end
            end
            // accepted reload, else count up on the prescaler tick
            if (wr_accept) begin
                next_st.count = sfr_wdata_in;
                next_st.power_control[WDG_RLE_BIT] = 1'b0;
            end else if (enabled && tick_if.tick) begin
                // idle bit is not looked at: idle keeps counting
                next_st.count = st.count + 8'h01;
            end
        end
        // pin may go low after power-down was set: drop it
        if (enabled) begin
            next_st.power_control[WDG_PD_BIT] = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st.power_control <= WDG_POWER_CONTROL_RESET;
            st.count <= WDG_COUNT_RESET;
            st.rst_cnt <= '0;
            st.rdata <= 8'h00;
            // pin reads as disabled until synchronised
            st.en_meta <= 1'b1;
            st.en_sync <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs all come from registers
    assign sfr_rdata_out = st.rdata;
    assign idle_out = st.power_control[WDG_IDLE_BIT];
    assign power_down_out = st.power_control[WDG_PD_BIT];
    assign internal_reset_out = pulse_on;
    // reset pin is active high; a capacitor on it may swallow the pulse
    assign rst_pin_out = pulse_on;
    assign rst_pin_oe_out = pulse_on;

    // helper: length of the current reset pin pulse
    int oe_len;
    always_ff @(posedge clk_in) begin
        if (srst_in || !rst_pin_oe_out) begin
            oe_len <= 0;
        end else begin
            oe_len <= oe_len + 1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    property p_count_up;
        enabled && tick_if.tick && !wr_accept && !pulse_on &&
        st.count != WDG_COUNT_MAX |=> st.count == $past(st.count) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance on tick");

    property p_ovf_reset;
        overflow |=> internal_reset_out && rst_pin_oe_out;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset)
        else $error("overflow gave no reset");

    property p_pulse_len;
        $fell(rst_pin_oe_out) |-> $past(oe_len) == WDG_RST_PULSE_CLKS - 1;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pin pulse length wrong");

    property p_no_reset_off;
        st.en_sync && !pulse_on |=> !internal_reset_out;
    endproperty
    a_no_reset_off: assert property (p_no_reset_off)
        else $error("reset while watchdog disabled");

    property p_reload_clears;
        wr_accept && !pulse_on |=>
        !st.power_control[WDG_RLE_BIT] && st.count == $past(sfr_wdata_in);
    endproperty
    a_reload_clears: assert property (p_reload_clears)
        else $error("accepted reload mishandled");

    property p_reload_blocked;
        wr_count && !st.power_control[WDG_RLE_BIT] && !tick_if.tick &&
        !pulse_on
        |=> st.count == $past(st.count);
    endproperty
    a_reload_blocked: assert property (p_reload_blocked)
        else $error("unguarded reload changed counter");

    property p_pd_locked;
        enabled |=> !power_down_out;
    endproperty
    a_pd_locked: assert property (p_pd_locked)
        else $error("power-down set while enabled");

    property p_idle_counts;
        // the overflow tick starts a reset instead of a count
        idle_out && enabled && tick_if.tick && !wr_accept && !pulse_on &&
        st.count != WDG_COUNT_MAX |=> st.count == $past(st.count) + 8'h01;
    endproperty
    a_idle_counts: assert property (p_idle_counts)
        else $error("counter frozen in idle");

    property p_reset_clears;
        // own disable: the default one would mask every attempt
        @(posedge clk_in) disable iff (1'b0) srst_in |=>
        st.count == WDG_COUNT_RESET && !st.power_control[WDG_RLE_BIT];
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left watchdog state");

    c_reload: cover property (wr_accept);
    c_blocked: cover property (wr_count && !st.power_control[WDG_RLE_BIT]);
    c_overflow: cover property (overflow);
    c_pd_refused: cover property (wr_pwr && enabled &&
                                  sfr_wdata_in[WDG_PD_BIT]);
endmodule : wdg_top
`default_nettype wire

// ---- dv/tb_wdg_top.sv ----
// self-checking bench for the reload-guarded watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_wdg_top;
    import wdg_pkg::*;
    localparam int PW = 2; // short prescaler keeps the run brief
    localparam int TICK = WDG_MC_DIV * (1 << PW); // clocks per count
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic en_n = 1'b1; // enable pin, high keeps the watchdog off
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic idle, pd, irst, pin, pin_oe;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    logic rd_q = 1'b0; // read taken at the last edge
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int hi = 0; // clocks of the current pulse
    int pulses = 0;
    int fall_cyc = 0;
    int rise_cyc = 0;
    integer seed = 13626;
    logic [7:0] v;
    logic [7:0] cur; // counter contents we expect
    logic fl;

    wdg_top #(.PRESC_WIDTH(PW)) dut (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .watchdog_enable_n_pin_in(en_n),
        .sfr_addr_in(addr),
        .sfr_wr_in(wr),
        .sfr_wdata_in(wdata),
        .sfr_rd_in(rd),
        .sfr_rdata_out(rdata),
        .idle_out(idle),
        .power_down_out(pd),
        .internal_reset_out(irst),
        .rst_pin_out(pin),
        .rst_pin_oe_out(pin_oe)
    );

    // free-running 50 MHz clock
    initial begin
        forever #10 clk_in = ~clk_in;
    end

    task finish_test;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task cmp8(input logic [7:0] got, input logic [7:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask : cmp8

    task cmpn(input int got, input int lo, input int up, input string s);
        checks++;
        if (got < lo || got > up) begin
            miscompares++;
            $display("mismatch at %0t: %s got %0d", $time, s, got);
        end
    endtask : cmpn

    // one-cycle write strobe, driven off the sampling edge
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask : wr_reg

    // read strobe; the monitor compares the answer a cycle later
    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk_in);
        rd = 1'b0;
    endtask : rd_reg

    // two-stage reload: guard bit first, then the counter
    task reload(input logic [7:0] d);
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h10);
        wr_reg(WDG_ADDR_COUNT, d);
    endtask : reload

    // bounded wait for the watchdog reset to rise
    task wait_rise(input int lim);
        int n;
        n = 0;
        while (irst !== 1'b1 && n < lim) begin
            @(negedge clk_in);
            n++;
        end
        // let the monitor's next edge count the rise first
        @(negedge clk_in);
    endtask : wait_rise

    // hang guard, well above the planned run length
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end

    // monitor: read answers and reset pulse shape, pre-update values
    always @(posedge clk_in) begin
        if (rd_q) begin
            cmp8(rdata, exp_q.pop_front(), "read data");
        end
        rd_q = rd;
        if (irst === 1'b1) begin
            if (hi == 0) begin
                pulses++;
                rise_cyc = cyc;
            end
            hi++;
            cmp8({6'h00, pin, pin_oe}, 8'h03, "reset pin");
        end else if (hi != 0) begin
            cmpn(hi, WDG_RST_PULSE_CLKS, WDG_RST_PULSE_CLKS, "width");
            hi = 0;
            fall_cyc = cyc;
        end
    end

    // main sequence
    initial begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        srst_in = 1'b0;
        rd_reg(WDG_ADDR_POWER_CONTROL, WDG_POWER_CONTROL_RESET);
        rd_reg(WDG_ADDR_COUNT, WDG_COUNT_RESET);
        rd_reg(8'h42, 8'h00); // unmapped place reads zero
        wr_reg(WDG_ADDR_COUNT, 8'h5a); // guard bit clear, refused
        rd_reg(WDG_ADDR_COUNT, 8'h00);
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h10);
        rd_reg(WDG_ADDR_POWER_CONTROL, 8'h10);
        wr_reg(WDG_ADDR_COUNT, 8'h9c);
        rd_reg(WDG_ADDR_COUNT, 8'h9c);
        rd_reg(WDG_ADDR_POWER_CONTROL, 8'h00);
        // random mix of guarded and unguarded counter writes
        cur = 8'h9c;
        repeat (8) begin
            v = $random(seed);
            fl = $random(seed);
            if (fl) begin
                wr_reg(WDG_ADDR_POWER_CONTROL, 8'h10);
                cur = v;
            end
            wr_reg(WDG_ADDR_COUNT, v);
            rd_reg(WDG_ADDR_COUNT, cur);
        end
        $display("reload guard tests done");
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h02);
        cmp8({7'h00, pd}, 8'h01, "power down off");
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h00);
        reload(8'h00);
        en_n = 1'b0;
        repeat (3) @(negedge clk_in);
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h02); // locked out while enabled
        cmp8({7'h00, pd}, 8'h00, "power down on");
        rd_reg(WDG_ADDR_POWER_CONTROL, 8'h00);
        // timely reloads keep the chip alive
        repeat (4) begin
            repeat (150) @(negedge clk_in);
            v = $random(seed);
            reload(v & 8'h7f);
        end
        cmpn(pulses, 0, 0, "pulses serviced");
        $display("power and service tests done");
        // idle keeps counting; shortest interval from all ones
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h11);
        cmp8({7'h00, idle}, 8'h01, "idle");
        wr_reg(WDG_ADDR_COUNT, 8'hff);
        wait_rise(2 * TICK);
        cmpn(pulses, 1, 1, "pulses idle");
        repeat (WDG_RST_PULSE_CLKS + 2) @(negedge clk_in);
        cmp8({7'h00, idle}, 8'h00, "idle cleared");
        rd_reg(WDG_ADDR_POWER_CONTROL, 8'h00);
        rd_reg(WDG_ADDR_COUNT, 8'h00);
        // longest interval: 256 counts from zero
        wait_rise(256 * TICK + 100);
        cmpn(rise_cyc - fall_cyc, 255 * TICK + TICK / 2,
            256 * TICK + TICK / 2, "interval");
        repeat (40) @(negedge clk_in);
        en_n = 1'b1;
        repeat (3) @(negedge clk_in);
        reload(8'hff);
        repeat (4 * TICK) @(negedge clk_in);
        cmpn(pulses, 2, 2, "pulses disabled");
        $display("overflow tests done");
        // chip reset in mid-run clears counter and reload guard
        wr_reg(WDG_ADDR_POWER_CONTROL, 8'h10);
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        rd_reg(WDG_ADDR_POWER_CONTROL, WDG_POWER_CONTROL_RESET);
        rd_reg(WDG_ADDR_COUNT, WDG_COUNT_RESET);
        $display("mid-run reset tests done");
        finish_test();
    end
endmodule : tb_wdg_top
`default_nettype wire
